// >>> hdl/pscr_regs.sv
/*
  Paged configuration register bank of pages 0 and 1: command decoder,
  page pointer, register store, shadow copies applied at exposure start.
  Assumes commands arrive already deframed from the serial link as a
  one-cycle strobe in the sys_clk domain; exposure trigger and sequencer
  ready come from pins and are synchronised here.
  The store behind the indirect port must answer in the cycle of its
  read pulse; no wait state is inserted. Only pages 0 and 1 are
  decoded: every other flat location reads zero and ignores writes.
  The acquisition path sees only the active copies, never the stored.
*/
// How it works
// - Register is page plus in-page address
// - Shadow writes take effect next exposure trigger
// - Soft reset restores factory register values
// - Defaults shown only after sequencer loaded
// - Read-only family and mask codes, page 0
// - Page-0 0x11 holds absolute EEPROM address
// - Page-0 0x12 moves EEPROM data indirectly
// - 0x22 frame-1 phase steps, default 0x34
// - Bits 3:2 gate pair one; codes direct
// - 0x25 frame-2 phase steps, default 0x3D
// - 0x24 bit 4 keeps light on
// - Bit 5 keeps light source off
// - 0x27 frame-2 light control, default zero
// - 0x3C grayscale light control, default 0x26
// - Opcode 100 selects persistent 3-bit page
// - Read 001, write 010 with address, data
// - Read answer echoes address and data
// - Opcode 110 reloads factory values, idles
`timescale 1ns/10ps
`default_nettype none
module pscr_regs #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] MASK_VERSION = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Command from the serial link
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [4:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // Response to the serial link
  output logic rsp_valid,
  output logic [2:0] rsp_id,
  output logic [4:0] rsp_addr,
  output logic [7:0] rsp_data,
  // Pins
  input wire logic exposure_trigger,
  input wire logic seq_loaded,
  // Non-volatile store, indirect port
  output logic nvm_wr,
  output logic nvm_rd,
  output logic [7:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  input wire logic [7:0] nvm_rdata,
  // Applied settings to the acquisition path
  output logic [1:0] f1_gate_pair_zero,
  output logic [1:0] f1_gate_pair_one,
  output logic [1:0] f2_gate_pair_zero,
  output logic [1:0] f2_gate_pair_one,
  output logic f1_light_source_on,
  output logic f1_light_source_off,
  output logic f2_light_source_on,
  output logic f2_light_source_off,
  output logic gray_light_source_on,
  output logic gray_light_source_off,
  output logic sys_ready
);

  typedef struct packed {
    // Page pointer of the host
    logic [2:0] page;

    // Indirect store port
    logic [7:0] nvm_addr;
    logic [7:0] nvm_data;

    // Stored copies, written by the host
    logic [7:0] f1_phase;
    logic [7:0] f1_light;
    logic [7:0] f2_phase;
    logic [7:0] f2_light;
    logic [7:0] gray_light;

    // Active copies, seen by the acquisition path
    logic [7:0] act_f1_phase;
    logic [7:0] act_f1_light;
    logic [7:0] act_f2_phase;
    logic [7:0] act_f2_light;
    logic [7:0] act_gray_light;

    // Boot count and trigger edge tracking
    logic [3:0] boot_cnt;
    logic ready;
    logic trig_q;

    // Registered store strobes
    logic nvm_wr;
    logic nvm_rd;

    // Response word
    logic rsp_valid;
    logic [2:0] rsp_id;
    logic [4:0] rsp_addr;
    logic [7:0] rsp_data;
  } pscr_regs_s;

  // Registered state and its next value
  pscr_regs_s state_ff;
  pscr_regs_s nxt_state;

  // Pin levels after the agreement filter
  logic trig_sync;
  logic loaded_sync;

  // Flat location from page pointer and in-page address
  // Page in the upper bits, so page 1 spans 0x20 to 0x3f
  function automatic logic [7:0] flat_loc(input logic [2:0] page, input logic [4:0] addr);
    flat_loc = {page, addr};
  endfunction

  // Pin synchronisers
  // Three stages each; a one-cycle glitch never passes
  pscr_sync u_trig_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(exposure_trigger),
    .dout(trig_sync)
  );

  pscr_sync u_loaded_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(seq_loaded),
    .dout(loaded_sync)
  );

  // Command decode, store, shadow transfer
  always_comb begin
    logic [7:0] loc;
    logic [7:0] rdval;
    loc = flat_loc(state_ff.page, cmd_addr);
    rdval = 8'h00;
    nxt_state = state_ff;
    nxt_state.rsp_valid = 1'b0;
    nxt_state.nvm_wr = 1'b0;
    nxt_state.nvm_rd = 1'b0;
    nxt_state.trig_q = trig_sync;

    // Indirect read data lands one cycle after the read pulse; placed
    // ahead of the command decode so that a data register write in
    // that same cycle wins over the data coming back
    if (state_ff.nvm_rd) begin
      nxt_state.nvm_data = nvm_rdata;
    end

    // Read mux; reserved locations read zero
    // Page 2 and up fall in the default arm
    case (loc)
      pscr_pkg::LOC_FAMILY: rdval = FAMILY_CODE;
      pscr_pkg::LOC_MASK_VER: rdval = MASK_VERSION;
      pscr_pkg::LOC_NVM_ADDR: rdval = state_ff.nvm_addr;
      pscr_pkg::LOC_NVM_DATA: rdval = state_ff.nvm_data;
      pscr_pkg::LOC_F1_PHASE: rdval = state_ff.f1_phase;
      pscr_pkg::LOC_F1_LIGHT: rdval = state_ff.f1_light;
      pscr_pkg::LOC_F2_PHASE: rdval = state_ff.f2_phase;
      pscr_pkg::LOC_F2_LIGHT: rdval = state_ff.f2_light;
      pscr_pkg::LOC_GRAY_LIGHT: rdval = state_ff.gray_light;
      default: rdval = 8'h00;
    endcase

    // Boot: wait for sequencer program, then a short settle count
    // Ready never falls again; a later drop of the pin is ignored
    if (!state_ff.ready) begin
      if (loaded_sync) begin
        if (state_ff.boot_cnt == pscr_pkg::BOOT_CYCLES) begin
          nxt_state.ready = 1'b1;
        end else begin
          nxt_state.boot_cnt = state_ff.boot_cnt + 4'h1;
        end
      end
    end

    // Shadow copies become active at the rising trigger edge
    // A write in the same cycle reaches the stored copy only
    if (trig_sync && !state_ff.trig_q) begin
      nxt_state.act_f1_phase = state_ff.f1_phase;
      nxt_state.act_f1_light = state_ff.f1_light;
      nxt_state.act_f2_phase = state_ff.f2_phase;
      nxt_state.act_f2_light = state_ff.f2_light;
      nxt_state.act_gray_light = state_ff.gray_light;
    end

    // One registered answer per command, standing one cycle
    if (cmd_valid) begin
      nxt_state.rsp_valid = 1'b1;
      nxt_state.rsp_addr = cmd_addr;
      nxt_state.rsp_data = 8'h00;
      if (!state_ff.ready) begin
        // Boot not finished: not-ready answer, command dropped
        nxt_state.rsp_id = pscr_pkg::RID_SPECIAL;
        nxt_state.rsp_addr = pscr_pkg::NRDY_ADDR;
        nxt_state.rsp_data = pscr_pkg::NRDY_DATA;
      end else begin
        case (cmd_op)
          // Poll: idle answer, nothing pending
          pscr_pkg::OP_NOP: begin
            nxt_state.rsp_id = pscr_pkg::RID_IDLE;
            nxt_state.rsp_addr = 5'h00;
          end

          // Read: address echoed with the register value
          pscr_pkg::OP_READ: begin
            nxt_state.rsp_id = pscr_pkg::RID_READ_DONE;
            nxt_state.rsp_data = rdval;
            if (loc == pscr_pkg::LOC_NVM_DATA) begin
              nxt_state.nvm_rd = 1'b1;
            end
          end

          // Write: stored copy or indirect port
          pscr_pkg::OP_WRITE: begin
            nxt_state.rsp_id = pscr_pkg::RID_WRITE_DONE;
            nxt_state.rsp_data = cmd_data;
            // Writes to read-only or reserved locations are ignored
            // The answer echoes the data even when it is not stored
            case (loc)
              pscr_pkg::LOC_NVM_ADDR: nxt_state.nvm_addr = cmd_data;
              pscr_pkg::LOC_NVM_DATA: begin
                nxt_state.nvm_data = cmd_data;
                nxt_state.nvm_wr = 1'b1;
              end
              pscr_pkg::LOC_F1_PHASE: nxt_state.f1_phase = cmd_data;
              pscr_pkg::LOC_F1_LIGHT: nxt_state.f1_light = cmd_data;
              pscr_pkg::LOC_F2_PHASE: nxt_state.f2_phase = cmd_data;
              pscr_pkg::LOC_F2_LIGHT: nxt_state.f2_light = cmd_data;
              pscr_pkg::LOC_GRAY_LIGHT: nxt_state.gray_light = cmd_data;
              default: nxt_state.rsp_data = cmd_data;
            endcase
          end

          // Quit: nothing is ever pending, so only the fixed answer
          pscr_pkg::OP_QUIT: begin
            nxt_state.rsp_id = pscr_pkg::RID_SPECIAL;
            nxt_state.rsp_addr = pscr_pkg::QUIT_ADDR;
            nxt_state.rsp_data = pscr_pkg::QUIT_DATA;
          end

          // Page select: pointer kept until the next select or soft reset
          pscr_pkg::OP_PAGE: begin
            nxt_state.page = cmd_addr[2:0];
            nxt_state.rsp_id = pscr_pkg::RID_PAGE;
            nxt_state.rsp_addr = {2'b00, cmd_addr[2:0]};
          end

          // Soft reset
          pscr_pkg::OP_RESET: begin
            // Factory values back, active copies too; answer idle
            // Active copies at once, so outputs need no trigger to recover
            nxt_state.page = pscr_pkg::RST_PAGE;
            nxt_state.nvm_addr = pscr_pkg::RST_NVM;
            nxt_state.nvm_data = pscr_pkg::RST_NVM;
            nxt_state.f1_phase = pscr_pkg::RST_F1_PHASE;
            nxt_state.f1_light = pscr_pkg::RST_F1_LIGHT;
            nxt_state.f2_phase = pscr_pkg::RST_F2_PHASE;
            nxt_state.f2_light = pscr_pkg::RST_F2_LIGHT;
            nxt_state.gray_light = pscr_pkg::RST_GRAY_LIGHT;
            nxt_state.act_f1_phase = pscr_pkg::RST_F1_PHASE;
            nxt_state.act_f1_light = pscr_pkg::RST_F1_LIGHT;
            nxt_state.act_f2_phase = pscr_pkg::RST_F2_PHASE;
            nxt_state.act_f2_light = pscr_pkg::RST_F2_LIGHT;
            nxt_state.act_gray_light = pscr_pkg::RST_GRAY_LIGHT;
            nxt_state.rsp_id = pscr_pkg::RID_IDLE;
            nxt_state.rsp_addr = 5'h00;
          end

          // Reserved opcodes
          default: begin
            // Reserved opcode: error answer
            nxt_state.rsp_id = pscr_pkg::RID_SPECIAL;
            nxt_state.rsp_addr = pscr_pkg::ERR_ADDR;
            nxt_state.rsp_data = pscr_pkg::ERR_DATA;
          end
        endcase
      end
    end
  end

  // Hardware reset gives factory values, same as the soft reset
  // Reset branch loads constants only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
      state_ff.f1_phase <= pscr_pkg::RST_F1_PHASE;
      state_ff.f1_light <= pscr_pkg::RST_F1_LIGHT;
      state_ff.f2_phase <= pscr_pkg::RST_F2_PHASE;
      state_ff.f2_light <= pscr_pkg::RST_F2_LIGHT;
      state_ff.gray_light <= pscr_pkg::RST_GRAY_LIGHT;
      state_ff.act_f1_phase <= pscr_pkg::RST_F1_PHASE;
      state_ff.act_f1_light <= pscr_pkg::RST_F1_LIGHT;
      state_ff.act_f2_phase <= pscr_pkg::RST_F2_PHASE;
      state_ff.act_f2_light <= pscr_pkg::RST_F2_LIGHT;
      state_ff.act_gray_light <= pscr_pkg::RST_GRAY_LIGHT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flip-flops
  assign rsp_valid = state_ff.rsp_valid;
  assign rsp_id = state_ff.rsp_id;
  assign rsp_addr = state_ff.rsp_addr;
  assign rsp_data = state_ff.rsp_data;

  // Store port and status
  assign nvm_wr = state_ff.nvm_wr;
  assign nvm_rd = state_ff.nvm_rd;
  assign nvm_addr = state_ff.nvm_addr;
  assign nvm_wdata = state_ff.nvm_data;
  assign sys_ready = state_ff.ready;

  // Selector codes map straight to step numbers
  assign f1_gate_pair_zero = state_ff.act_f1_phase[pscr_pkg::PAIR0_LSB +: 2];
  assign f1_gate_pair_one = state_ff.act_f1_phase[pscr_pkg::PAIR1_LSB +: 2];
  assign f2_gate_pair_zero = state_ff.act_f2_phase[pscr_pkg::PAIR0_LSB +: 2];
  assign f2_gate_pair_one = state_ff.act_f2_phase[pscr_pkg::PAIR1_LSB +: 2];

  // Light source control bits of the active copies
  assign f1_light_source_on = state_ff.act_f1_light[pscr_pkg::LIGHT_ON_BIT];
  assign f1_light_source_off = state_ff.act_f1_light[pscr_pkg::LIGHT_OFF_BIT];
  assign f2_light_source_on = state_ff.act_f2_light[pscr_pkg::LIGHT_ON_BIT];
  assign f2_light_source_off = state_ff.act_f2_light[pscr_pkg::LIGHT_OFF_BIT];
  assign gray_light_source_on = state_ff.act_gray_light[pscr_pkg::LIGHT_ON_BIT];
  assign gray_light_source_off = state_ff.act_gray_light[pscr_pkg::LIGHT_OFF_BIT];

endmodule
`default_nettype wire

// >>> inc/pscr_pkg.sv
/*
  Package of the paged sensor configuration registers: command and
  response codes, flat register locations, factory values and field
  positions. Assumes nothing of its surroundings.
*/
package pscr_pkg;

  // Command opcodes
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_QUIT = 3'h3;
  localparam logic [2:0] OP_PAGE = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h6;

  // Response identifiers and fixed answer words
  localparam logic [2:0] RID_IDLE = 3'h0;
  localparam logic [2:0] RID_READ_DONE = 3'h1;
  localparam logic [2:0] RID_WRITE_DONE = 3'h2;
  localparam logic [2:0] RID_PAGE = 3'h4;
  localparam logic [2:0] RID_SPECIAL = 3'h7;
  localparam logic [4:0] QUIT_ADDR = 5'h03;
  localparam logic [7:0] QUIT_DATA = 8'h8e;
  localparam logic [4:0] ERR_ADDR = 5'h15;
  localparam logic [7:0] ERR_DATA = 8'hff;
  localparam logic [4:0] NRDY_ADDR = 5'h0b;
  localparam logic [7:0] NRDY_DATA = 8'hff;

  // Flat register locations (page * 32 + in-page address)
  localparam logic [7:0] LOC_FAMILY = 8'h00;
  localparam logic [7:0] LOC_MASK_VER = 8'h01;
  localparam logic [7:0] LOC_NVM_ADDR = 8'h11;
  localparam logic [7:0] LOC_NVM_DATA = 8'h12;
  localparam logic [7:0] LOC_F1_PHASE = 8'h22;
  localparam logic [7:0] LOC_F1_LIGHT = 8'h24;
  localparam logic [7:0] LOC_F2_PHASE = 8'h25;
  localparam logic [7:0] LOC_F2_LIGHT = 8'h27;
  localparam logic [7:0] LOC_GRAY_LIGHT = 8'h3c;

  // Factory values
  localparam logic [7:0] RST_F1_PHASE = 8'h34;
  localparam logic [7:0] RST_F1_LIGHT = 8'h00;
  localparam logic [7:0] RST_F2_PHASE = 8'h3d;
  localparam logic [7:0] RST_F2_LIGHT = 8'h00;
  localparam logic [7:0] RST_GRAY_LIGHT = 8'h26;
  localparam logic [7:0] RST_NVM = 8'h00;
  localparam logic [2:0] RST_PAGE = 3'h0;

  // Field positions
  localparam int PAIR0_LSB = 0;
  localparam int PAIR1_LSB = 2;
  localparam int LIGHT_ON_BIT = 4;
  localparam int LIGHT_OFF_BIT = 5;

  // Boot: settle cycles counted after the sequencer download before defaults show
  localparam logic [3:0] BOOT_CYCLES = 4'h8;

endpackage

// >>> hdl/pscr_sync.sv
/*
  Three-stage input synchroniser with agreement filter for one pin level.
  Assumes sys_clk and arst_n of the register block.
*/
`timescale 1ns/10ps
`default_nettype none
module pscr_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Level
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } pscr_sync_s;

  pscr_sync_s state_ff;
  pscr_sync_s nxt_state;

  // Stage 0 feeds only stage 1; level follows once stages 1 and 2 agree
  always_comb begin
    nxt_state = state_ff;
    nxt_state.stage = {state_ff.stage[1:0], din};
    if (state_ff.stage[1] == state_ff.stage[2]) begin
      nxt_state.level = state_ff.stage[2];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dout = state_ff.level;

endmodule
`default_nettype wire

// >>> verification/pscr_nvm_model.sv
/*
  Non-volatile store model behind the indirect port of the register bank.
  Assumes the bank's nvm outputs and the same single clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pscr_nvm_model (
  // Clock
  input wire logic sys_clk,
  // Indirect port
  input wire logic nvm_wr,
  input wire logic [7:0] nvm_addr,
  input wire logic [7:0] nvm_wdata,
  output logic [7:0] nvm_rdata
);
  logic [7:0] mem [256];
  // Unwritten cells read as the inverted address, so stale data shows
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~8'(i);
    end
  end
  // Store on the write pulse at the absolute address
  always @(posedge sys_clk) begin
    if (nvm_wr) begin
      mem[nvm_addr] <= nvm_wdata;
    end
  end
  // Always valid, so the one-cycle read pulse never waits
  assign nvm_rdata = mem[nvm_addr];
endmodule
`default_nettype wire

// >>> verification/pscr_regs_props.sv
/*
  Concurrent checks of the register bank at its ports.
  Assumes one clock domain; bound to every pscr_regs instance.
*/
`timescale 1ns/10ps
`default_nettype none
module pscr_regs_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Command and response
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [4:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_id,
  input wire logic [4:0] rsp_addr,
  input wire logic [7:0] rsp_data,
  // Pins and applied settings
  input wire logic exposure_trigger,
  input wire logic seq_loaded,
  input wire logic [1:0] f1_gate_pair_zero,
  input wire logic [1:0] f1_gate_pair_one,
  input wire logic f1_light_source_on,
  input wire logic gray_light_source_off,
  input wire logic sys_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Trigger pin low long enough that no apply can be pending
  sequence trig_quiet;
    (!exposure_trigger)[*8];
  endsequence
  sequence cmd_ok(logic [2:0] op);
    cmd_valid && sys_ready && cmd_op == op;
  endsequence
  // Answers, one cycle after the command
  a_read_echo: assert property (cmd_ok(pscr_pkg::OP_READ) |=> rsp_valid
    && rsp_id == pscr_pkg::RID_READ_DONE && rsp_addr == $past(cmd_addr)) else $error("read answer");
  a_write_echo: assert property (cmd_ok(pscr_pkg::OP_WRITE) |=> rsp_id == 3'h2
    && rsp_addr == $past(cmd_addr) && rsp_data == $past(cmd_data)) else $error("write answer");
  a_page_answer: assert property (cmd_ok(pscr_pkg::OP_PAGE) |=> rsp_id == 3'h4
    && rsp_addr == {2'h0, $past(cmd_addr[2:0])}) else $error("page answer");
  a_soft_reset: assert property (cmd_ok(pscr_pkg::OP_RESET) |=> rsp_id == 3'h0
    && f1_gate_pair_zero == 2'h0 && f1_gate_pair_one == 2'h1 && gray_light_source_off)
    else $error("soft reset");
  a_boot_refuse: assert property (cmd_valid && !sys_ready |=> rsp_id == 3'h7
    && rsp_addr == 5'h0b && rsp_data == 8'hff) else $error("boot answer");
  a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray answer");
  a_ready_cause: assert property ($rose(sys_ready) |-> $past(seq_loaded, 9))
    else $error("ready early");
  a_shadow_hold: assert property (trig_quiet |=> ($stable(f1_gate_pair_zero)
    && $stable(f1_light_source_on))
    || $past(cmd_valid && sys_ready && cmd_op == pscr_pkg::OP_RESET))
    else $error("shadow applied early");
endmodule
bind pscr_regs pscr_regs_props u_pscr_regs_props (.sys_clk, .arst_n, .cmd_valid, .cmd_op,
  .cmd_addr, .cmd_data, .rsp_valid, .rsp_id, .rsp_addr, .rsp_data, .exposure_trigger,
  .seq_loaded, .f1_gate_pair_zero, .f1_gate_pair_one, .f1_light_source_on,
  .gray_light_source_off, .sys_ready);
`default_nettype wire

// >>> verification/testbench.sv
/*
  Self-checking testbench of the register bank acting as host.
  Assumes pscr_pkg, the bank, the store model and the checker compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [4:0] cmd_addr = 5'h00;
  logic [7:0] cmd_data = 8'h00;
  logic exposure_trigger = 1'b0;
  logic seq_loaded = 1'b0;
  logic rsp_valid, nvm_wr, nvm_rd, sys_ready;
  logic [2:0] rsp_id;
  logic [4:0] rsp_addr;
  logic [7:0] rsp_data, nvm_addr, nvm_wdata, nvm_rdata;
  logic [1:0] f1_gate_pair_zero, f1_gate_pair_one, f2_gate_pair_zero, f2_gate_pair_one;
  logic f1_light_source_on, f1_light_source_off, f2_light_source_on, f2_light_source_off;
  logic gray_light_source_on, gray_light_source_off;
  logic [31:0] seed = 32'h6ae2;
  logic [7:0] ph, li;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] locs [5] = '{8'h02, 8'h04, 8'h05, 8'h07, 8'h1c};
  logic [7:0] defs [5] = '{8'h34, 8'h00, 8'h3d, 8'h00, 8'h26};
  wire [15:0] rsp = {rsp_id, rsp_addr, rsp_data};
  pscr_regs #(.FAMILY_CODE(8'h3c), .MASK_VERSION(8'h77)) u_pscr_regs (.sys_clk, .arst_n,
    .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .rsp_valid, .rsp_id, .rsp_addr, .rsp_data,
    .exposure_trigger, .seq_loaded, .nvm_wr, .nvm_rd, .nvm_addr, .nvm_wdata, .nvm_rdata,
    .f1_gate_pair_zero, .f1_gate_pair_one, .f2_gate_pair_zero, .f2_gate_pair_one,
    .f1_light_source_on, .f1_light_source_off, .f2_light_source_on, .f2_light_source_off,
    .gray_light_source_on, .gray_light_source_off, .sys_ready);
  pscr_nvm_model u_pscr_nvm_model (.sys_clk, .nvm_wr, .nvm_addr, .nvm_wdata, .nvm_rdata);
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Expected 2-bit step selector of a gate pair
  function automatic logic [1:0] sel(input logic [7:0] v, input int pair);
    return v[2 * pair +: 2];
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One idle edge first, so the strobe is never set twice in one step
  task automatic cmd(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    chk("rsp_valid", 16'(rsp_valid), 16'h0001);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    cmd(pscr_pkg::OP_READ, a, 8'h00);
    chk("read", rsp, {3'h1, a, exp});
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cmd(pscr_pkg::OP_WRITE, a, d);
    chk("write", rsp, {3'h2, a, d});
  endtask
  // Trigger pulse, then time for sync and apply
  task automatic trig;
    exposure_trigger = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    exposure_trigger = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    cmd(pscr_pkg::OP_NOP, 5'h00, 8'h00);
    chk("boot", rsp, {3'h7, 5'h0b, 8'hff});
    seq_loaded = 1'b1;
    for (int i = 0; i < 40 && sys_ready !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("ready", 16'(sys_ready), 16'h0001);
    cmd(pscr_pkg::OP_PAGE, 5'h01, 8'h00);
    chk("page", rsp, {3'h4, 5'h01, 8'h00});
    for (int i = 0; i < 5; i++) begin
      rd(locs[i][4:0], defs[i]);
    end
    ph = 8'h34;
    li = 8'h00;
    wr(5'h05, 8'h3e);
    wr(5'h07, 8'h20);
    wr(5'h1c, 8'h16);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      wr(5'h02, k == 0 ? 8'h3b : {4'h3, seed[3:0]});
      wr(5'h04, {2'h0, k == 1 ? 2'h3 : seed[9:8], 4'h0});
      chk("held", {f1_gate_pair_one, f1_gate_pair_zero}, {sel(ph, 1), sel(ph, 0)});
      chk("held_light", 16'(f1_light_source_on), 16'(li[4]));
      ph = k == 0 ? 8'h3b : {4'h3, seed[3:0]};
      li = {2'h0, k == 1 ? 2'h3 : seed[9:8], 4'h0};
      trig();
      chk("pairs", {f1_gate_pair_one, f1_gate_pair_zero}, {sel(ph, 1), sel(ph, 0)});
      chk("light", {f1_light_source_off, f1_light_source_on}, 16'(li[5:4]));
      rd(5'h02, ph);
    end
    chk("f2", {f2_gate_pair_one, f2_gate_pair_zero}, {sel(8'h3e, 1), sel(8'h3e, 0)});
    chk("f2_light", {f2_light_source_off, f2_light_source_on}, 16'h0002);
    chk("gray", {gray_light_source_off, gray_light_source_on}, 16'h0001);
    cmd(pscr_pkg::OP_PAGE, 5'h00, 8'h00);
    wr(5'h01, 8'ha5);
    rd(5'h01, 8'h77);
    rd(5'h00, 8'h3c);
    wr(5'h11, 8'h40);
    wr(5'h12, 8'h5c);
    chk("nvm_wr", 16'(nvm_wr), 16'h0001);
    chk("nvm_addr", 16'(nvm_addr), 16'h0040);
    wr(5'h11, 8'h41);
    wr(5'h12, 8'hc3);
    wr(5'h11, 8'h40);
    rd(5'h12, 8'hc3);
    chk("nvm_rd", 16'(nvm_rd), 16'h0001);
    rd(5'h12, 8'h5c);
    cmd(pscr_pkg::OP_RESET, 5'h00, 8'h00);
    chk("reset", rsp, 16'h0000);
    chk("reset_out", {f1_gate_pair_one, f1_gate_pair_zero}, 16'h0004);
    rd(5'h01, 8'h77);
    cmd(pscr_pkg::OP_PAGE, 5'h01, 8'h00);
    rd(5'h02, 8'h34);
    rd(5'h07, 8'h00);
    cmd(pscr_pkg::OP_QUIT, 5'h00, 8'h00);
    chk("quit", rsp, {3'h7, 5'h03, 8'h8e});
    cmd(3'h5, 5'h00, 8'h00);
    chk("reserved_op", rsp, {3'h7, 5'h15, 8'hff});
    end_of_test;
  end
endmodule
`default_nettype wire
